/* dxph_pkg.sv */
// ---------------------------------------------------------------
// shared constants for the pin handshake block
// ---------------------------------------------------------------
package dxph_pkg;
    localparam int          DATA_W      = 32;     // external data bus width
    localparam int          NUM_CHAN    = 4;      // dma channels
    localparam int          SHARED_CHAN = 3;      // channel whose pins change role
    localparam int          BUF_DEPTH   = 2;      // entries in the read buffer
    localparam int          XSIZE_W     = 2;      // external transfer size width
    localparam logic        SIO_SEL_DSR = 1'b0;   // config bit value: dsr / dtr
    localparam logic        SIO_SEL_CTS = 1'b1;   // config bit value: cts / rts
    localparam logic [3:0]  REQ_RST     = 4'h0;   // sampled requests after reset
    localparam logic [3:0]  ACK_RST     = 4'h0;   // acknowledges after reset
    localparam logic [31:0] DATA_RST    = 32'h0;  // data register after reset
    localparam logic [1:0]  XSIZE_RST   = 2'h0;   // size bits after reset

    // bus ownership, one-hot
    typedef enum logic [1:0] {
        DXPH_OWN_DEV = 2'b01,                     // device is bus master
        DXPH_OWN_EXT = 2'b10                      // external master owns bus
    } dxph_own_t;
endpackage : dxph_pkg

/* dxph_buf2.sv */
`timescale 1ns/100ps
// ---------------------------------------------------------------
// small valid/ready buffer, default two entries
// ---------------------------------------------------------------
module dxph_buf2 #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_ff [DEPTH];             // storage
    logic [PW-1:0]    wr_ptr_ff, nxt_wr_ptr;      // write index
    logic [PW-1:0]    rd_ptr_ff, nxt_rd_ptr;      // read index
    logic [PW:0]      cnt_ff, nxt_cnt;            // fill level
    logic             push, pop;

    // honest flags
    assign in_ready  = (cnt_ff != DEPTH[PW:0]);
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rd_ptr_ff];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // wrapping pointer step
    function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
        step = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction : step

    // next pointer and level
    always_comb begin
        nxt_wr_ptr = push ? step(wr_ptr_ff) : wr_ptr_ff;
        nxt_rd_ptr = pop ? step(rd_ptr_ff) : rd_ptr_ff;
        nxt_cnt    = cnt_ff;
        if (push && !pop) begin
            nxt_cnt = (PW+1)'(cnt_ff + 1'b1);
        end else if (pop && !push) begin
            nxt_cnt = (PW+1)'(cnt_ff - 1'b1);
        end
    end

    // register pointers
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff    <= '0;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            cnt_ff    <= nxt_cnt;
        end
    end

    // storage write, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    buf_nooverflow_a : assert property (@(posedge clk) disable iff (srst)
        (cnt_ff == DEPTH[PW:0]) |-> !push)
        else $error("buffer written while full");
endmodule : dxph_buf2

/* dxph_top.sv */
`timescale 1ns/100ps
// Function
// - 32-bit data bus, bit 0 most significant
// - ack held during channel transfer
// - shared request: dma3 owned, else external
// - shared ack marks external data valid
// - read strobe on a dram read by the bus owner only
// - write strobe on a dram write by the bus owner only
// - config bit picks dsr or cts
// - same bit picks dtr or rts
// - shared eot pin is external size bit
module dxph_top
    import dxph_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                srst,
    // ownership from the bus arbiter
    input  wire logic                dev_owns_bus,
    // dma request and acknowledge pins
    input  wire logic                chan0_xfer_request_n,
    input  wire logic                chan1_xfer_request_n,
    input  wire logic                chan2_xfer_request_n,
    input  wire logic                chan3_xfer_request_n,
    output logic                     chan0_xfer_ack,
    output logic                     chan1_xfer_ack,
    output logic                     chan2_xfer_ack,
    output logic                     chan3_xfer_ack,
    // shared eot / size pins
    input  wire logic                ext_xfer_size_bit0,
    input  wire logic                ext_xfer_size_bit1,
    // dram strobes
    output logic                     mem_read_strobe,
    output logic                     mem_write_strobe,
    // data bus pins, index 0 is the msb
    input  wire logic [0:DATA_W-1]   data_in,
    output logic      [0:DATA_W-1]   data_out,
    output logic                     data_oe,
    // serial modem pins and config bit
    input  wire logic                serial_cfg_sel,
    input  wire logic                modem_in,
    output logic                     modem_out,
    // core side: dma engine
    input  wire logic [NUM_CHAN-1:0] dma_xfer_active,
    input  wire logic                dma_eot_in,
    output logic      [NUM_CHAN-1:0] dma_req,
    output logic                     chan3_eot_n,
    // core side: external master path
    output logic                     ext_master_request,
    output logic                     ext_master_ack,
    output logic      [XSIZE_W-1:0]  ext_xfer_size,
    input  wire logic                ext_data_valid,
    input  wire logic                ext_mem_rd,
    input  wire logic                ext_mem_wr,
    // core side: device dram access
    input  wire logic                dev_mem_rd,
    input  wire logic                dev_mem_wr,
    input  wire logic                wr_drive,
    input  wire logic [DATA_W-1:0]   wr_data,
    input  wire logic                rd_capture,
    output logic                     rd_capture_ready,
    output logic                     rd_valid,
    input  wire logic                rd_ready,
    output logic      [DATA_W-1:0]   rd_data,
    // core side: serial port
    input  wire logic                sio_dtr,
    input  wire logic                sio_rts,
    output logic                     sio_dsr,
    output logic                     sio_cts,
    output logic                     role_ext
);
    // ---------------------------------------------------------------
    // ownership state
    // ---------------------------------------------------------------
    dxph_own_t own_ff, nxt_own;                   // common role of shared pins

    // switch only when the shared pins are quiet
    always_comb begin
        nxt_own = own_ff;
        unique case (own_ff)
            DXPH_OWN_DEV: begin
                if (!dev_owns_bus && !dma_xfer_active[SHARED_CHAN]) begin
                    nxt_own = DXPH_OWN_EXT;
                end
            end
            DXPH_OWN_EXT: begin
                if (dev_owns_bus && !ext_data_valid) begin
                    nxt_own = DXPH_OWN_DEV;
                end
            end
            default: begin
                nxt_own = DXPH_OWN_DEV;           // illegal code recovers
            end
        endcase
    end

    // register role
    always_ff @(posedge clk) begin
        if (srst) begin
            own_ff <= DXPH_OWN_DEV;
        end else begin
            own_ff <= nxt_own;
        end
    end

    logic is_ext;                                 // external master has the bus
    assign is_ext   = (own_ff == DXPH_OWN_EXT);
    assign role_ext = is_ext;

    // ---------------------------------------------------------------
    // requests, acknowledges, size bits
    // ---------------------------------------------------------------
    logic [NUM_CHAN-1:0] req_ff, nxt_req;         // dma requests to core
    logic                ext_master_request_n_ff, nxt_ext_master_request_n;       // external master request
    logic [NUM_CHAN-1:0] ack_ff, nxt_ack;         // acknowledge pins
    logic [XSIZE_W-1:0]  xsize_ff, nxt_xsize;     // captured size bits
    logic                eot_ff, nxt_eot;         // channel 3 end of transfer

    // role-dependent decode of the shared pins
    always_comb begin
        nxt_req = ~{chan3_xfer_request_n, chan2_xfer_request_n,
                    chan1_xfer_request_n, chan0_xfer_request_n};
        nxt_req[SHARED_CHAN] = !is_ext && !chan3_xfer_request_n;
        nxt_ext_master_request_n  = is_ext && !chan3_xfer_request_n;
        nxt_ack   = dma_xfer_active;
        nxt_ack[SHARED_CHAN] = is_ext ? ext_data_valid
                                      : dma_xfer_active[SHARED_CHAN];
        nxt_xsize = is_ext ? {ext_xfer_size_bit1, ext_xfer_size_bit0}
                           : xsize_ff;
        nxt_eot   = is_ext ? 1'b1 : ext_xfer_size_bit0;
    end

    // register handshake state
    always_ff @(posedge clk) begin
        if (srst) begin
            req_ff   <= REQ_RST;
            ext_master_request_n_ff  <= 1'b0;
            ack_ff   <= ACK_RST;
            xsize_ff <= XSIZE_RST;
            eot_ff   <= 1'b1;
        end else begin
            req_ff   <= nxt_req;
            ext_master_request_n_ff  <= nxt_ext_master_request_n;
            ack_ff   <= nxt_ack;
            xsize_ff <= nxt_xsize;
            eot_ff   <= nxt_eot;
        end
    end

    assign dma_req            = req_ff;
    assign ext_master_request = ext_master_request_n_ff;
    assign chan0_xfer_ack     = ack_ff[0];
    assign chan1_xfer_ack     = ack_ff[1];
    assign chan2_xfer_ack     = ack_ff[2];
    assign chan3_xfer_ack     = ack_ff[SHARED_CHAN];
    assign ext_master_ack     = ack_ff[SHARED_CHAN] && is_ext;
    assign ext_xfer_size      = xsize_ff;
    assign chan3_eot_n        = eot_ff && !dma_eot_in;

    // ---------------------------------------------------------------
    // dram strobes
    // ---------------------------------------------------------------
    logic rd_stb_ff, nxt_rd_stb;                  // read strobe
    logic wr_stb_ff, nxt_wr_stb;                  // write strobe

    // either master may read or write a bank
    always_comb begin
        nxt_rd_stb = (!is_ext && dev_mem_rd) || (is_ext && ext_mem_rd);
        nxt_wr_stb = (!is_ext && dev_mem_wr) || (is_ext && ext_mem_wr);
    end

    // register strobes
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_stb_ff <= 1'b0;
            wr_stb_ff <= 1'b0;
        end else begin
            rd_stb_ff <= nxt_rd_stb;
            wr_stb_ff <= nxt_wr_stb;
        end
    end

    assign mem_read_strobe  = rd_stb_ff;
    assign mem_write_strobe = wr_stb_ff;

    // ---------------------------------------------------------------
    // data bus
    // ---------------------------------------------------------------
    logic [DATA_W-1:0] dout_ff, nxt_dout;         // driven word
    logic              doe_ff, nxt_doe;           // drive enable
    logic [DATA_W-1:0] din_word;                  // pins as msb-first word

    // pin index 0 lands on word bit 31, so numeric value is kept
    assign din_word = data_in;

    // drive only as bus owner and never during a read strobe
    always_comb begin
        nxt_doe  = wr_drive && !is_ext && !nxt_rd_stb;
        nxt_dout = wr_drive ? wr_data : dout_ff;
    end

    // register data outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            dout_ff <= DATA_RST;
            doe_ff  <= 1'b0;
        end else begin
            dout_ff <= nxt_dout;
            doe_ff  <= nxt_doe;
        end
    end

    assign data_out = dout_ff;
    assign data_oe  = doe_ff;

    // read words wait here if the core stalls
    dxph_buf2 #(
        .WIDTH (DATA_W),
        .DEPTH (BUF_DEPTH)
    ) u_rd_buf (
        .clk       (clk),
        .srst      (srst),
        .in_valid  (rd_capture),
        .in_ready  (rd_capture_ready),
        .in_data   (din_word),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );

    // ---------------------------------------------------------------
    // serial modem pins
    // ---------------------------------------------------------------
    logic dsr_ff, nxt_dsr;                        // modem input as dsr
    logic cts_ff, nxt_cts;                        // modem input as cts
    logic mout_ff, nxt_mout;                      // modem output pin

    // one config bit steers both directions
    always_comb begin
        nxt_dsr  = (serial_cfg_sel == SIO_SEL_DSR) ? modem_in : dsr_ff;
        nxt_cts  = (serial_cfg_sel == SIO_SEL_CTS) ? modem_in : cts_ff;
        nxt_mout = (serial_cfg_sel == SIO_SEL_DSR) ? sio_dtr : sio_rts;
    end

    // register modem signals
    always_ff @(posedge clk) begin
        if (srst) begin
            dsr_ff  <= 1'b0;
            cts_ff  <= 1'b0;
            mout_ff <= 1'b0;
        end else begin
            dsr_ff  <= nxt_dsr;
            cts_ff  <= nxt_cts;
            mout_ff <= nxt_mout;
        end
    end

    assign sio_dsr   = dsr_ff;
    assign sio_cts   = cts_ff;
    assign modem_out = mout_ff;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    ack_follows_xfer_a : assert property (@(posedge clk) disable iff (srst)
        dma_xfer_active[0] |=> chan0_xfer_ack)
        else $error("channel ack missing during transfer");
    shared_req_role_a : assert property (@(posedge clk) disable iff (srst)
        (is_ext && $past(is_ext) && $past(!chan3_xfer_request_n)) |-> !dma_req[SHARED_CHAN])
        else $error("channel 3 request leaked in external role");
    ext_req_seen_a : assert property (@(posedge clk) disable iff (srst)
        (is_ext && !chan3_xfer_request_n) |=> ext_master_request)
        else $error("external request not seen");
    ext_ack_valid_a : assert property (@(posedge clk) disable iff (srst)
        (is_ext && ext_data_valid) |=> chan3_xfer_ack)
        else $error("external ack not driven on valid data");
    rd_strobe_a : assert property (@(posedge clk) disable iff (srst)
        (!is_ext && dev_mem_rd) |=> mem_read_strobe)
        else $error("read strobe missing");
    wr_strobe_a : assert property (@(posedge clk) disable iff (srst)
        (is_ext && ext_mem_wr) |=> mem_write_strobe)
        else $error("write strobe missing for external master");
    modem_out_sel_a : assert property (@(posedge clk) disable iff (srst)
        (serial_cfg_sel == SIO_SEL_CTS) |=> (modem_out == $past(sio_rts)))
        else $error("modem output not rts");
    size_capture_a : assert property (@(posedge clk) disable iff (srst)
        is_ext |=> (ext_xfer_size[0] == $past(ext_xfer_size_bit0)))
        else $error("size bit not captured");
    own_switch_a : assert property (@(posedge clk) disable iff (srst)
        (own_ff == DXPH_OWN_DEV && dma_xfer_active[SHARED_CHAN]) |=> own_ff == DXPH_OWN_DEV)
        else $error("role switched during channel 3 transfer");
endmodule : dxph_top

/* dxph_far_model.sv */
`timescale 1ns/100ps
// ---------------------------------------------------------------
// far side: peripherals, external master and dram bank
// ---------------------------------------------------------------
module dxph_far_model
    import dxph_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [3:0]        want,            // per-channel service wish
    input  wire logic [1:0]        size_val,        // external transfer size
    input  wire logic [31:0]       bank_word,       // word the bank holds
    input  wire logic              mem_read_strobe, // bank output enable
    output logic      [3:0]        req_n,           // request pins
    output logic                   size0,           // shared eot / size pin
    output logic                   size1,           // second size pin
    output logic      [0:DATA_W-1] data_in          // data bus pins
);
    logic [0:DATA_W-1] last_ff = '0;                // last bus value seen

    // requests pull low while service is wanted
    assign req_n = ~want;
    // size pins driven by the external master
    assign size0 = size_val[0];
    assign size1 = size_val[1];
    // bank drives only on a read strobe, else the bus keeps changing
    assign data_in = mem_read_strobe ? bank_word : ~last_ff;

    // remember the bus so a released bus never looks stable
    always @(posedge clk) begin
        last_ff <= data_in;
    end
endmodule : dxph_far_model

/* dma_and_ext_master_pin_handshake_test.sv */
`timescale 1ns/100ps
// ---------------------------------------------------------------
// self-checking bench for the pin handshake block
// ---------------------------------------------------------------
module dma_and_ext_master_pin_handshake_test;
    import dxph_pkg::*;
    logic              clk = 1'b0, srst = 1'b1, dev_owns_bus = 1'b1;  // clock, reset, arbiter
    logic [3:0]        want = 4'h0, act = 4'h0, req_n, dma_req, ack;  // dma side
    logic [1:0]        size_val = 2'h0, ext_xfer_size;                // size pins and result
    logic [31:0]       bank_word = 32'h0, wr_data = 32'h0, rd_data;   // data words
    logic [0:DATA_W-1] data_in, data_out;                             // bus pins
    logic              eot_in = 1'b0, ext_dv = 1'b0, ext_rd = 1'b0, ext_wr = 1'b0;
    logic              dev_rd = 1'b0, dev_wr = 1'b0, wr_drive = 1'b0, rd_capture = 1'b0;
    logic              rd_ready = 1'b0, sel = 1'b0, modem_in = 1'b0, dtr = 1'b0, rts = 1'b0;
    logic              s0, s1, eot_n, ext_req, ext_ack, rds, wrs, data_oe, modem_out;
    logic              cap_rdy, rd_valid, dsr, cts, role_ext;
    int                fails = 0, n_tests = 0;                        // verdict counters
    logic [31:0]       q[$];                                          // buffer model

    // ---------------------------------------------------------------
    // clock and instances
    // ---------------------------------------------------------------
    initial begin
        forever #10 clk = ~clk;
    end

    dxph_far_model u_far (.clk(clk), .want(want), .size_val(size_val), .bank_word(bank_word),
        .mem_read_strobe(rds), .req_n(req_n), .size0(s0), .size1(s1), .data_in(data_in));

    dxph_top u_dut (.clk(clk), .srst(srst), .dev_owns_bus(dev_owns_bus),
        .chan0_xfer_request_n(req_n[0]), .chan1_xfer_request_n(req_n[1]),
        .chan2_xfer_request_n(req_n[2]), .chan3_xfer_request_n(req_n[3]),
        .chan0_xfer_ack(ack[0]), .chan1_xfer_ack(ack[1]), .chan2_xfer_ack(ack[2]),
        .chan3_xfer_ack(ack[3]), .ext_xfer_size_bit0(s0), .ext_xfer_size_bit1(s1),
        .mem_read_strobe(rds), .mem_write_strobe(wrs), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .serial_cfg_sel(sel), .modem_in(modem_in), .modem_out(modem_out),
        .dma_xfer_active(act), .dma_eot_in(eot_in), .dma_req(dma_req), .chan3_eot_n(eot_n),
        .ext_master_request(ext_req), .ext_master_ack(ext_ack), .ext_xfer_size(ext_xfer_size),
        .ext_data_valid(ext_dv), .ext_mem_rd(ext_rd), .ext_mem_wr(ext_wr), .dev_mem_rd(dev_rd),
        .dev_mem_wr(dev_wr), .wr_drive(wr_drive), .wr_data(wr_data), .rd_capture(rd_capture),
        .rd_capture_ready(cap_rdy), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
        .sio_dtr(dtr), .sio_rts(rts), .sio_dsr(dsr), .sio_cts(cts), .role_ext(role_ext));

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one cycle: inputs land at the rise, results read at the fall
    task automatic tick;
        @(posedge clk);
        @(negedge clk);
    endtask : tick

    // print the verdict and end the run
    task automatic stop_test;
        if (fails == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    // bounded wait for the ownership state, then one cycle for decode
    task automatic wait_role(input logic v);
        int k;
        for (k = 0; k < 10 && role_ext !== v; k++) begin
            tick();
        end
        if (role_ext !== v) begin
            fails++;
            stop_test();
        end
        tick();
    endtask : wait_role

    // random traffic while the device owns the bus
    task automatic run_dev(input int n);
        repeat (n) begin
            want = 4'($urandom);
            act = 4'($urandom);
            size_val = 2'($urandom);
            wr_data = $urandom;
            {eot_in, dev_rd, dev_wr, ext_dv, wr_drive, sel, modem_in, dtr, rts} = 9'($urandom);
            tick();
            chk("dma_req", dma_req, want);
            chk("ack", ack, act);
            chk("ext_req", ext_req, 1'b0);
            chk("ext_ack", ext_ack, 1'b0);
            chk("rd_strobe", rds, dev_rd);
            chk("wr_strobe", wrs, dev_wr);
            chk("eot_n", eot_n, s0 & ~eot_in);
            chk("data_oe", data_oe, wr_drive & ~dev_rd);
            if (wr_drive && !dev_rd) begin
                chk("data_out", data_out, wr_data);
            end
            chk("modem_out", modem_out, sel ? rts : dtr);
            if (sel == SIO_SEL_DSR) begin
                chk("dsr", dsr, modem_in);
            end else begin
                chk("cts", cts, modem_in);
            end
        end
    endtask : run_dev

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(21234));
        repeat (4) @(negedge clk);
        chk("ack_rst", ack, ACK_RST);
        chk("req_rst", dma_req, REQ_RST);
        chk("role_rst", role_ext, 1'b0);
        chk("cap_rdy_rst", cap_rdy, 1'b1);
        chk("rd_valid_rst", rd_valid, 1'b0);
        srst = 1'b0;
        run_dev(40);
        // fill the buffer past full while the reader stalls
        {want, wr_drive, dev_wr, dev_rd} = {4'h0, 3'b001};
        tick();
        repeat (3) begin
            bank_word = $urandom;
            rd_capture = 1'b1;
            chk("cap_rdy", cap_rdy, q.size() < BUF_DEPTH);
            if (q.size() < BUF_DEPTH) begin
                q.push_back(bank_word);
            end
            tick();
        end
        rd_capture = 1'b0;
        rd_ready = 1'b1;
        while (q.size() > 0) begin
            chk("rd_valid", rd_valid, 1'b1);
            chk("rd_data", rd_data, q.pop_front());
            tick();
        end
        chk("rd_empty", rd_valid, 1'b0);
        // hand the bus to the external master
        {dev_owns_bus, act} = 5'h0;
        wait_role(1'b1);
        repeat (30) begin
            want = 4'($urandom);
            act = {1'b0, 3'($urandom)};
            size_val = 2'($urandom);
            {ext_dv, ext_rd, ext_wr, dev_rd, dev_wr, wr_drive} = 6'($urandom);
            tick();
            chk("dma_req_x", dma_req, {1'b0, want[2:0]});
            chk("ext_req_x", ext_req, want[3]);
            chk("ack_x", ack, {ext_dv, act[2:0]});
            chk("ext_ack_x", ext_ack, ext_dv);
            chk("rd_strobe_x", rds, ext_rd);
            chk("wr_strobe_x", wrs, ext_wr);
            chk("size_x", ext_xfer_size, size_val);
            chk("data_oe_x", data_oe, 1'b0);
        end
        // take the bus back and run again
        {dev_owns_bus, ext_dv} = 2'b10;
        wait_role(1'b0);
        run_dev(30);
        stop_test();
    end
endmodule : dma_and_ext_master_pin_handshake_test
